// ===== rtl/audio_infoframe_status_regs.sv
// Audio packet status register group with Wishbone slave and interrupt
`timescale 1ns/1ps
`include "audio_status_params.svh"

module audio_infoframe_status_regs (
  input  wire logic                             clk_in,          // 50 MHz clock
  input  wire logic                             reset_n_in,      // Async reset, low
  input  wire logic                             wb_cyc_in,       // Bus cycle
  input  wire logic                             wb_stb_in,       // Strobe
  input  wire logic                             wb_we_in,        // Write enable
  input  wire logic [31:0]                      wb_adr_in,       // Byte address
  input  wire logic [3:0]                       wb_sel_in,       // Byte lanes
  input  wire logic [31:0]                      wb_dat_in,       // Write data
  output logic      [31:0]                      wb_dat_out,      // Read data
  output logic                                  wb_ack_out,      // Acknowledge
  input  wire logic                             audio_load_in,   // New audio fields
  input  wire audio_status_pkg::audio_fields_type audio_fields_in, // Audio fields
  input  wire logic                             spd_load_in,     // New SPD fields
  input  wire audio_status_pkg::spd_fields_type spd_fields_in,   // SPD fields
  input  wire audio_status_pkg::flag_vec_type   packet_changed_in, // Change pulses
  input  wire logic                             flags_read_other_in, // Other copy read
  output audio_status_pkg::flag_vec_type        changed_packet_flags_out, // Flags
  output logic                                  flags_read_out,  // This copy read
  output logic                                  irq_out          // Interrupt level
);
  import audio_status_pkg::*;

  // ****************************************
  // Reset release
  // ****************************************
  logic             rst_meta;
  logic             rst_n;

  // Release goes through two flops so every flop leaves reset together
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ****************************************
  // Stored packet fields
  // ****************************************
  audio_fields_type aud;
  spd_fields_type   spd;
  flag_vec_type     flags;
  flag_vec_type     irq_status;
  flag_vec_type     irq_mask;
  flag_vec_type     flag_set;
  flag_vec_type     status_clear;
  logic             audio_differs;
  logic             spd_differs;

  // Fields only move when the parser delivers a packet; bus writes never touch them
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aud <= '0;
    end else if (audio_load_in) begin
      aud <= audio_fields_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      spd <= '0;
    end else if (spd_load_in) begin
      spd <= spd_fields_in;
    end
  end

  // Change detection for the two packets this group stores itself
  assign audio_differs = audio_load_in && (audio_fields_in != aud);
  assign spd_differs   = spd_load_in && (spd_fields_in != spd);

  // One bit per packet kind; the other kinds come in as pulses
  always_comb begin
    flag_set              = packet_changed_in;
    flag_set[`FLAG_AUDIO] = packet_changed_in[`FLAG_AUDIO] | audio_differs;
    flag_set[`FLAG_SPD]   = packet_changed_in[`FLAG_SPD] | spd_differs;
  end

  // ****************************************
  // Wishbone slave
  // ****************************************
  logic             req;
  logic             mapped;
  logic [7:0]       word_idx;
  logic             commit;
  logic             read_copy;
  logic             wr_lane0;

  // Word index from the byte address
  function automatic logic [7:0] index_of(input logic [31:0] adr);
    return adr[9:2];
  endfunction

  // High address bits must be clear for a hit
  function automatic logic in_window(input logic [31:0] adr);
    return adr[31:10] == 22'h000000;
  endfunction

  assign req      = wb_cyc_in && wb_stb_in;
  assign word_idx = index_of(wb_adr_in);
  assign mapped   = in_window(wb_adr_in);

  // Effects land on the edge at which the master samples ack high
  assign commit    = req && wb_ack_out;
  assign read_copy = commit && !wb_we_in && mapped && (word_idx == `IDX_FLAGS_COPY);
  assign wr_lane0  = commit && wb_we_in && mapped && wb_sel_in[0];

  // Ack one cycle after the request, then drop so the master can release
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= req && !wb_ack_out;
    end
  end

  // Read mux; unmapped and reserved locations and unused bits read zero
  function automatic logic [31:0] read_word(input logic [7:0] idx, input logic hit);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (!hit) begin
      w = 32'h0000_0000;
    end else if (idx == `IDX_AUDIO_VERSION) begin
      w[7:0] = aud.version;
    end else if (idx == `IDX_CODING) begin
      w[`FMT_LO +: 4] = aud.audio_format_code;
      w[`CHN_LO +: 3] = aud.channel_number_code;
    end else if (idx == `IDX_RATE_WIDTH) begin
      w[`RATE_LO +: 3] = aud.sample_rate_code;
      w[`SIZE_LO +: 2] = aud.sample_size_code;
    end else if (idx == `IDX_PEAK_RATE) begin
      w[7:0] = aud.peak_rate;
    end else if (idx == `IDX_LAYOUT) begin
      w[7:0] = aud.speaker_layout;
    end else if (idx == `IDX_DOWNMIX) begin
      w[`DMX_BIT]        = aud.downmix_block;
      w[`SHIFT_LO +: 4]  = aud.level_shift_db;
    end else if (idx == `IDX_SPARE) begin
      w = 32'h0000_0000;
    end else if (idx == `IDX_FLAGS_COPY) begin
      w[6:0] = flags;
    end else if (idx == `IDX_SPD_VERSION) begin
      w[7:0] = spd.version;
    end else if (idx == `IDX_VENDOR_CHAR) begin
      w[6:0] = spd.vendor_char_first;
    end else if (idx == `IDX_IRQ_STATUS) begin
      w[6:0] = irq_status;
    end else if (idx == `IDX_IRQ_MASK) begin
      w[6:0] = irq_mask;
    end
    return w;
  endfunction

  // Data is captured with ack so it stands while the master samples it
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (req && !wb_ack_out && !wb_we_in) begin
      wb_dat_out <= read_word(word_idx, mapped);
    end else if (!req) begin
      wb_dat_out <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Packet-change flags, shared with the other copies
  // ****************************************
  // Any copy read clears all; a change in the same cycle still shows
  sticky_flag_bank u_flags (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n),
    .set_in       (flag_set),
    .clear_all_in (read_copy || flags_read_other_in),
    .clear_in     ('0),
    .bits_out     (flags)
  );

  assign changed_packet_flags_out = flags;
  assign flags_read_out           = read_copy;

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Write one to clear; lanes other than byte 0 carry nothing
  assign status_clear = (wr_lane0 && word_idx == `IDX_IRQ_STATUS) ? wb_dat_in[6:0] : '0;

  sticky_flag_bank u_irq_status (
    .clk_in       (clk_in),
    .rst_n_in     (rst_n),
    .set_in       (flag_set),
    .clear_all_in (1'b0),
    .clear_in     (status_clear),
    .bits_out     (irq_status)
  );

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `MASK_RST;
    end else if (wr_lane0 && word_idx == `IDX_IRQ_MASK) begin
      irq_mask <= wb_dat_in[6:0];
    end
  end

  // Registered so the line never glitches during a status clear
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_read_take(logic [7:0] idx);
    req && !wb_ack_out && !wb_we_in && mapped && word_idx == idx;
  endsequence

  sequence s_quiet_fields;
    !audio_load_in && !spd_load_in;
  endsequence

  property p_format_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_CODING) |=>
        wb_ack_out && wb_dat_out[7:4] == $past(aud.audio_format_code);
  endproperty
  a_format_read: assert property (p_format_read)
    else $error("Format code read wrong");

  property p_channels_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_CODING) |=>
        wb_dat_out[2:0] == $past(aud.channel_number_code) && wb_dat_out[3] == 1'b0;
  endproperty
  a_channels_read: assert property (p_channels_read)
    else $error("Channel count read wrong");

  property p_rate_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_RATE_WIDTH) |=>
        wb_dat_out[4:2] == $past(aud.sample_rate_code) && wb_dat_out[7:5] == 3'h0;
  endproperty
  a_rate_read: assert property (p_rate_read)
    else $error("Sample rate read wrong");

  property p_size_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_RATE_WIDTH) |=> wb_dat_out[1:0] == $past(aud.sample_size_code);
  endproperty
  a_size_read: assert property (p_size_read)
    else $error("Sample size read wrong");

  // Capture and read-back are checked apart; a read never follows a load by one cycle
  property p_layout_load;
    @(posedge clk_in) disable iff (!rst_n)
      audio_load_in |=> aud.speaker_layout == $past(audio_fields_in.speaker_layout);
  endproperty
  a_layout_load: assert property (p_layout_load)
    else $error("Speaker layout not passed through");

  property p_layout_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_LAYOUT) |=>
        wb_ack_out && wb_dat_out[7:0] == $past(aud.speaker_layout);
  endproperty
  a_layout_read: assert property (p_layout_read)
    else $error("Speaker layout read wrong");

  property p_downmix_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_DOWNMIX) |=> wb_dat_out[7] == $past(aud.downmix_block);
  endproperty
  a_downmix_read: assert property (p_downmix_read)
    else $error("Down-mix flag read wrong");

  property p_shift_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_DOWNMIX) |=>
        wb_dat_out[6:3] == $past(aud.level_shift_db) && wb_dat_out[2:0] == 3'h0;
  endproperty
  a_shift_read: assert property (p_shift_read)
    else $error("Level shift read wrong");

  property p_copy_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_FLAGS_COPY) |=> wb_dat_out[6:0] == $past(flags) && !wb_dat_out[7];
  endproperty
  a_copy_read: assert property (p_copy_read)
    else $error("Flag copy does not match flags");

  property p_read_clears;
    @(posedge clk_in) disable iff (!rst_n)
      (read_copy && flag_set == '0) |=> flags == `FLAGS_RST ##1 !wb_ack_out;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("Flag read did not clear");

  property p_audio_flag;
    @(posedge clk_in) disable iff (!rst_n)
      audio_differs |=> flags[`FLAG_AUDIO] && irq_status[`FLAG_AUDIO];
  endproperty
  a_audio_flag: assert property (p_audio_flag)
    else $error("Audio change flag not set");

  property p_vendor_read;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_VENDOR_CHAR) |=>
        wb_dat_out[6:0] == $past(spd.vendor_char_first) && !wb_dat_out[7];
  endproperty
  a_vendor_read: assert property (p_vendor_read)
    else $error("Vendor character read wrong");

  property p_write_ignored;
    @(posedge clk_in) disable iff (!rst_n)
      (commit && wb_we_in) and s_quiet_fields |=> aud == $past(aud) && spd == $past(spd);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("Bus write changed a field");

  property p_spare_zero;
    @(posedge clk_in) disable iff (!rst_n)
      s_read_take(`IDX_SPARE) |=> wb_ack_out && wb_dat_out == 32'h0000_0000;
  endproperty
  a_spare_zero: assert property (p_spare_zero)
    else $error("Reserved location not zero");

endmodule // audio_infoframe_status_regs

// ===== rtl/audio_status_params.svh
// Constants for the audio packet status register group
`ifndef AUDIO_STATUS_PARAMS_SVH
`define AUDIO_STATUS_PARAMS_SVH

// ****************************************
// Register indices, byte address is four times the index
// ****************************************
`define IDX_AUDIO_VERSION  8'h90
`define IDX_CODING         8'h91
`define IDX_RATE_WIDTH     8'h92
`define IDX_PEAK_RATE      8'h93
`define IDX_LAYOUT         8'h94
`define IDX_DOWNMIX        8'h95
`define IDX_SPARE          8'h96
`define IDX_FLAGS_COPY     8'h97
`define IDX_SPD_VERSION    8'h98
`define IDX_VENDOR_CHAR    8'h99
`define IDX_IRQ_STATUS     8'hc0
`define IDX_IRQ_MASK       8'hc1

// ****************************************
// Field positions
// ****************************************
`define FMT_LO             4
`define CHN_LO             0
`define RATE_LO            2
`define SIZE_LO            0
`define DMX_BIT            7
`define SHIFT_LO           3

// ****************************************
// Packet-change flag bits
// ****************************************
`define FLAG_VIDEO         0
`define FLAG_AUDIO         1
`define FLAG_SPD           2
`define FLAG_MPEG          3
`define FLAG_PROT          4
`define FLAG_REC1          5
`define FLAG_REC2          6

// ****************************************
// Reset values
// ****************************************
`define FIELD_RST          8'h00
`define FLAGS_RST          7'h00
`define MASK_RST           7'h00

`endif

// ===== rtl/audio_status_pkg.sv
// Types shared by the audio packet status register group
package audio_status_pkg;

  // Decoded audio information packet fields from the parser
  typedef struct packed {
    logic [7:0] version;
    logic [3:0] audio_format_code;
    logic [2:0] channel_number_code;
    logic [2:0] sample_rate_code;
    logic [1:0] sample_size_code;
    logic [7:0] peak_rate;
    logic [7:0] speaker_layout;
    logic       downmix_block;
    logic [3:0] level_shift_db;
  } audio_fields_type;

  // Start of the source product description packet
  typedef struct packed {
    logic [7:0] version;
    logic [6:0] vendor_char_first;
  } spd_fields_type;

  typedef logic [6:0] flag_vec_type;

endpackage

// ===== rtl/sticky_flag_bank.sv
// Sticky flag bank: set pulses win over clears
`timescale 1ns/1ps
`include "audio_status_params.svh"

module sticky_flag_bank (
  input  wire logic                         clk_in,       // System clock
  input  wire logic                         rst_n_in,     // Synchronised reset
  input  wire audio_status_pkg::flag_vec_type set_in,     // Per-bit set pulses
  input  wire logic                         clear_all_in, // Clear every bit
  input  wire audio_status_pkg::flag_vec_type clear_in,   // Per-bit clears
  output      audio_status_pkg::flag_vec_type bits_out      // Flag state
);
  import audio_status_pkg::*;

  flag_vec_type clear_vec;

  // A whole-bank clear overrides the per-bit pattern
  assign clear_vec = clear_all_in ? '1 : clear_in;

  // Set is or-ed in last so an event in the clear cycle survives
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bits_out <= `FLAGS_RST;
    end else begin
      bits_out <= (bits_out & ~clear_vec) | set_in;
    end
  end

  property p_set_wins;
    @(posedge clk_in) disable iff (!rst_n_in)
      (set_in != '0) |=> ((bits_out & $past(set_in)) == $past(set_in));
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("A set pulse was lost");

  property p_clear_all;
    @(posedge clk_in) disable iff (!rst_n_in)
      (clear_all_in && set_in == '0) |=> bits_out == `FLAGS_RST;
  endproperty
  a_clear_all: assert property (p_clear_all)
    else $error("Clear did not empty the bank");

endmodule // sticky_flag_bank

// ===== sim/audio_infoframe_status_regs_test.sv
// Self-checking bench for the audio packet status register group
`timescale 1ns/1ps
`include "audio_status_params.svh"

module audio_infoframe_status_regs_test;
  import audio_status_pkg::*;

  logic             clk_in = 1'h0;
  logic             reset_n = 1'h0;
  logic             cyc = 1'h0;
  logic             stb = 1'h0;
  logic             we = 1'h0;
  logic [31:0]      adr = 32'h0;
  logic [3:0]       sel = 4'h0;
  logic [31:0]      dat_w = 32'h0;
  logic [31:0]      dat_r;
  logic             ack;
  logic             a_load;
  audio_fields_type a_f;
  logic             s_load;
  spd_fields_type   s_f;
  flag_vec_type     chg;
  logic             other;
  flag_vec_type     flags;
  logic             flags_rd;
  logic             irq;
  logic             rd_flag;
  logic [31:0]      r;
  audio_fields_type ea = '0;
  spd_fields_type   es = '0;
  int               n_errors = 0;
  int               n_compared = 0;

  always #10 clk_in = ~clk_in;

  audio_infoframe_status_regs dut (.clk_in(clk_in), .reset_n_in(reset_n), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w),
    .wb_dat_out(dat_r), .wb_ack_out(ack), .audio_load_in(a_load), .audio_fields_in(a_f),
    .spd_load_in(s_load), .spd_fields_in(s_f), .packet_changed_in(chg),
    .flags_read_other_in(other), .changed_packet_flags_out(flags),
    .flags_read_out(flags_rd), .irq_out(irq));

  parser_model u_parser (.clk_in(clk_in), .audio_load_out(a_load), .audio_out(a_f),
    .spd_load_out(s_load), .spd_out(s_f), .changed_out(chg), .other_read_out(other));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic cycle; waits for ack under a bound, data taken at the ack edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    k = 0;
    @(posedge clk_in);
    cyc   <= 1'h1;
    stb   <= 1'h1;
    we    <= w;
    adr   <= {22'h0, idx, 2'h0};
    dat_w <= {24'h0, wd};
    sel   <= 4'h1;
    do begin
      @(posedge clk_in);
      k++;
    end while (ack !== 1'h1 && k < 40);
    if (k >= 40) chk(32'h0, 32'h1);
    r       = dat_r;
    rd_flag = flags_rd;
    cyc     <= 1'h0;
    stb     <= 1'h0;
    we      <= 1'h0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    xfer(1'h0, idx, 8'h00);
    chk(r, {24'h0, exp});
  endtask

  // Expected register image built from the fields last sent
  function automatic logic [7:0] exp_reg(input logic [7:0] idx);
    case (idx)
      `IDX_AUDIO_VERSION: return ea.version;
      `IDX_CODING: return {ea.audio_format_code, 1'h0, ea.channel_number_code};
      `IDX_RATE_WIDTH: return {3'h0, ea.sample_rate_code, ea.sample_size_code};
      `IDX_PEAK_RATE: return ea.peak_rate;
      `IDX_LAYOUT: return ea.speaker_layout;
      `IDX_DOWNMIX: return {ea.downmix_block, ea.level_shift_db, 3'h0};
      `IDX_SPD_VERSION: return es.version;
      `IDX_VENDOR_CHAR: return {1'h0, es.vendor_char_first};
      default: return 8'h00;
    endcase
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  // Format codes 0 to 8, every channel count and rate code, with extreme shifts
  task automatic t_audio;
    for (int i = 0; i <= 8; i++) begin
      ea.version             = 8'h10 + 8'(i);
      ea.audio_format_code   = 4'(i);
      ea.channel_number_code = 3'(i);
      ea.sample_rate_code    = ~3'(i);
      ea.sample_size_code    = 2'(i);
      ea.peak_rate           = 8'h93 ^ 8'(i);
      ea.speaker_layout      = {4'(i), ~4'(i)};
      ea.downmix_block       = i[0];
      ea.level_shift_db      = i[0] ? 4'hf : 4'h0;
      u_parser.load_audio(ea);
      for (int a = 8'h90; a <= 8'h96; a++) rd_chk(8'(a), exp_reg(8'(a)));
    end
    rd_chk(`IDX_FLAGS_COPY, 8'h02);
    chk(32'(rd_flag), 32'h1);
    $display("t_audio done");
  endtask

  // Vendor character, then writes to words 0x90 to 0x99 and an unmapped word
  task automatic t_spd_writes;
    es.version           = 8'h42;
    es.vendor_char_first = 7'h7f;
    u_parser.load_spd(es);
    rd_chk(`IDX_FLAGS_COPY, 8'h04);
    for (int a = 8'h90; a <= 8'h99; a++) begin
      xfer(1'h1, 8'(a), 8'hff);
      rd_chk(8'(a), exp_reg(8'(a)));
    end
    xfer(1'h1, 8'h50, 8'hff);
    rd_chk(8'h50, 8'h00);
    $display("t_spd_writes done");
  endtask

  // Each packet kind sets its own bit; any copy read clears all
  task automatic t_flags;
    for (int b = 0; b < 7; b++) begin
      u_parser.pulse(7'h01 << b, 1'h0);
      @(posedge clk_in);
      chk(32'(flags), 32'h1 << b);
      rd_chk(`IDX_FLAGS_COPY, 8'h01 << b);
      @(posedge clk_in);
      chk(32'(flags), 32'h0);
    end
    u_parser.pulse(7'h7f, 1'h0);
    u_parser.pulse(7'h00, 1'h1);
    @(posedge clk_in);
    chk(32'(flags), 32'h0);
    chk(32'(irq), 32'h0);
    $display("t_flags done");
  endtask

  // Masked event stays quiet, unmasked one raises the level, clear drops it
  task automatic t_irq;
    xfer(1'h1, `IDX_IRQ_STATUS, 8'h7f);
    rd_chk(`IDX_IRQ_STATUS, 8'h00);
    xfer(1'h1, `IDX_IRQ_MASK, 8'h04);
    rd_chk(`IDX_IRQ_MASK, 8'h04);
    u_parser.pulse(7'h01, 1'h0);
    repeat (2) @(posedge clk_in);
    chk(32'(irq), 32'h0);
    u_parser.pulse(7'h04, 1'h0);
    repeat (2) @(posedge clk_in);
    chk(32'(irq), 32'h1);
    rd_chk(`IDX_IRQ_STATUS, 8'h05);
    xfer(1'h1, `IDX_IRQ_STATUS, 8'h04);
    repeat (2) @(posedge clk_in);
    chk(32'(irq), 32'h0);
    rd_chk(`IDX_IRQ_STATUS, 8'h01);
    rd_chk(`IDX_FLAGS_COPY, 8'h05);
    $display("t_irq done");
  endtask

  // ****************************************
  // Verdict and run control
  // ****************************************
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (6000) @(posedge clk_in);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    reset_n <= 1'h1;
    repeat (4) @(posedge clk_in);
    rd_chk(`IDX_SPARE, 8'h00);
    rd_chk(`IDX_FLAGS_COPY, 8'h00);
    t_audio();
    t_spd_writes();
    t_flags();
    t_irq();
    test_done();
  end
endmodule // audio_infoframe_status_regs_test

// ===== sim/parser_model.sv
// Behavioural packet parser that feeds decoded fields and change pulses
`timescale 1ns/1ps

module parser_model (
  input  wire logic                         clk_in,         // System clock
  output logic                              audio_load_out, // Audio fields strobe
  output audio_status_pkg::audio_fields_type audio_out,     // Audio fields
  output logic                              spd_load_out,   // SPD fields strobe
  output audio_status_pkg::spd_fields_type  spd_out,        // SPD fields
  output audio_status_pkg::flag_vec_type    changed_out,    // Change pulses
  output logic                              other_read_out  // Another copy was read
);
  import audio_status_pkg::*;

  // ****************************************
  // Idle levels
  // ****************************************
  initial begin
    audio_load_out = 1'h0;
    audio_out      = '0;
    spd_load_out   = 1'h0;
    spd_out        = '0;
    changed_out    = 7'h00;
    other_read_out = 1'h0;
  end

  // Fields are inverted after the strobe so a late capture is seen
  task automatic load_audio(input audio_fields_type f);
    @(posedge clk_in);
    audio_out      <= f;
    audio_load_out <= 1'h1;
    @(posedge clk_in);
    audio_out      <= ~f;
    audio_load_out <= 1'h0;
  endtask

  task automatic load_spd(input spd_fields_type f);
    @(posedge clk_in);
    spd_out      <= f;
    spd_load_out <= 1'h1;
    @(posedge clk_in);
    spd_out      <= ~f;
    spd_load_out <= 1'h0;
  endtask

  // One-cycle change pulses, one bit per packet kind
  task automatic pulse(input flag_vec_type v, input logic other);
    @(posedge clk_in);
    changed_out    <= v;
    other_read_out <= other;
    @(posedge clk_in);
    changed_out    <= 7'h00;
    other_read_out <= 1'h0;
  endtask
endmodule // parser_model
